// ===== shared/isr_pkg.sv
// Constants shared by both ends of the two-wire register port.
// Assumes a 100 MHz host clock and an eight-byte register file.
package isr_pkg;
	localparam int          ISR_NUM_REGS      = 8;
	localparam int          ISR_PTR_W         = 3;
	localparam logic [3:0]  ISR_ADDR_HI       = 4'hB;
	localparam logic [1:0]  ISR_ADDR_LO       = 2'h0;
	localparam logic [2:0]  ISR_STATUS_REG    = 3'h7;
	localparam int          ISR_STATUS_POS    = 7;
	localparam logic [63:0] ISR_REG_RESET     = 64'h0000_0000_0000_0000;
	localparam logic [3:0]  ISR_BITS_PER_BYTE = 4'h8;
	localparam int          ISR_CLK_PERIOD_NS = 10;
	localparam int          ISR_SCL_PERIOD_NS = 10000;
	localparam int          ISR_SCL_QUARTER   = ISR_SCL_PERIOD_NS / (4 * ISR_CLK_PERIOD_NS);

	typedef enum logic [3:0] {
		ISR_S_IDLE  = 4'h0,
		ISR_S_ADDR  = 4'h1,
		ISR_S_ACKA  = 4'h3,
		ISR_S_PTR   = 4'h2,
		ISR_S_ACKP  = 4'h6,
		ISR_S_WDATA = 4'h7,
		ISR_S_ACKW  = 4'h5,
		ISR_S_RDATA = 4'h4,
		ISR_S_RACK  = 4'hC
	} isr_slave_state_t;

	typedef enum logic [2:0] {
		ISR_H_IDLE   = 3'h0,
		ISR_H_START  = 3'h1,
		ISR_H_XFER   = 3'h3,
		ISR_H_RSTART = 3'h2,
		ISR_H_STOP   = 3'h6
	} isr_host_state_t;

	typedef enum logic [2:0] {
		ISR_K_ADDRW = 3'h0,
		ISR_K_PTR   = 3'h1,
		ISR_K_DATA  = 3'h3,
		ISR_K_ADDRR = 3'h2,
		ISR_K_RD    = 3'h6
	} isr_byte_kind_t;
endpackage

// ===== shared/isr_if.sv
// Two-wire bus between the master end and the register slave end.
// Both lines are open drain with a pull-up; each driver only pulls low.
interface isr_if;
	logic sclHostOut;
	logic sclHostOe;
	logic sdaHostOut;
	logic sdaHostOe;
	logic sdaDevOut;
	logic sdaDevOe;
	logic scl;
	logic sda;

	// Wired-AND with pull-up
	assign scl = !(sclHostOe && !sclHostOut);
	assign sda = !((sdaHostOe && !sdaHostOut) || (sdaDevOe && !sdaDevOut));

	modport host (output sclHostOut, sclHostOe, sdaHostOut, sdaHostOe, input scl, sda);
	modport dev  (output sdaDevOut, sdaDevOe, input scl, sda);
endinterface

// ===== hdl/isr_sync3.sv
// Three-stage input synchroniser with agreement filter.
// Assumes asynchronous inputs; output changes once stages two and three agree.
module isr_sync3 #(
	parameter int           W    = 1,
	parameter logic [W-1:0] INIT = '0
) (
	input  wire logic         clock,
	input  wire logic         rst_b,
	input  wire logic [W-1:0] din,
	output logic      [W-1:0] dout
);
	logic [W-1:0] stage1;
	logic [W-1:0] stage2;
	logic [W-1:0] stage3;
	wire  [W-1:0] agree;
	wire  [W-1:0] next_dout;

	if (W < 1) begin : g_chk
		$error("isr_sync3 needs W >= 1");
	end

	assign agree     = ~(stage2 ^ stage3);
	assign next_dout = (agree & stage2) | (~agree & dout);

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			stage1 <= INIT;
			stage2 <= INIT;
			stage3 <= INIT;
			dout   <= INIT;
		end else begin
			stage1 <= din;
			stage2 <= stage1;
			stage3 <= stage2;
			dout   <= next_dout;
		end
	end
endmodule

// ===== hdl/isr_slave_end.sv
// Register slave end: two-wire protocol engine over an eight-byte register file.
// Assumes a free-running local link clock much faster than SCL; SCL comes from the master.
module isr_slave_end
	import isr_pkg::*;
#(
	parameter int NUM_REGS = ISR_NUM_REGS
) (
	input  wire logic                  linkClk,
	input  wire logic                  rst_b,
	isr_if.dev                         bus,
	input  wire logic                  addrSel,
	input  wire logic                  lockStatus,
	output logic      [8*NUM_REGS-1:0] cfgOut,
	output logic                       busActive
);
	isr_slave_state_t       state;
	isr_slave_state_t       next_state;
	logic             [7:0] shift;
	logic             [7:0] next_shift;
	logic             [3:0] bitCnt;
	logic             [3:0] next_bitCnt;
	logic [ISR_PTR_W-1:0]   ptr;
	logic [ISR_PTR_W-1:0]   next_ptr;
	logic                   rnw;
	logic                   next_rnw;
	logic                   masterNack;
	logic                   next_masterNack;
	logic                   sdaLow;
	logic                   next_sdaLow;
	logic                   sclPrev;
	logic                   sdaPrev;
	logic             [3:0] syncOut;

	wire sclNow    = syncOut[3];
	wire sdaNow    = syncOut[2];
	wire addrSelS  = syncOut[1];
	wire lockLive  = syncOut[0];
	wire sclRise   = sclNow && !sclPrev;
	wire sclFall   = !sclNow && sclPrev;
	wire startSeen = sclNow && sclPrev && sdaPrev && !sdaNow;
	wire stopSeen  = sclNow && sclPrev && !sdaPrev && sdaNow;
	wire byteDone  = bitCnt == ISR_BITS_PER_BYTE;
	wire [6:0] ownAddr = {ISR_ADDR_HI, addrSelS, ISR_ADDR_LO};
	wire addrHit   = shift[7:1] == ownAddr;
	wire commitNow = sclFall && !startSeen && !stopSeen
		&& state == ISR_S_WDATA && byteDone;
	wire [7:0] txByte  = readByte(cfgOut, ptr, lockLive);

	if (NUM_REGS != 8) begin : g_chk
		$error("isr_slave_end serves exactly eight registers");
	end

	// Register contents as seen by a read; top status bit is live
	function automatic logic [7:0] readByte(
		input logic [63:0]          regs,
		input logic [ISR_PTR_W-1:0] p,
		input logic                 live
	);
		logic [7:0] b;
		b = regs[{p, 3'h0} +: 8];
		if (p == ISR_STATUS_REG) begin
			b[ISR_STATUS_POS] = live;
		end
		return b;
	endfunction

	// SCL, SDA and straps come from pins; lines idle high
	isr_sync3 #(
		.W    (4),
		.INIT (4'hC)
	) u_sync (
		.clock (linkClk),
		.rst_b (rst_b),
		.din   ({bus.scl, bus.sda, addrSel, lockStatus}),
		.dout  (syncOut)
	);

	assign bus.sdaDevOut = 1'b0;
	assign bus.sdaDevOe  = sdaLow;

	always_comb begin
		next_state      = state;
		next_shift      = shift;
		next_bitCnt     = bitCnt;
		next_ptr        = ptr;
		next_rnw        = rnw;
		next_masterNack = masterNack;
		next_sdaLow     = sdaLow;
		if (stopSeen) begin
			next_state  = ISR_S_IDLE;
			next_sdaLow = 1'b0;
		end else if (startSeen) begin
			next_state  = ISR_S_ADDR;
			next_bitCnt = 4'h0;
			next_sdaLow = 1'b0;
		end else if (sclRise) begin
			case (state)
				ISR_S_ADDR, ISR_S_PTR, ISR_S_WDATA: begin
					next_shift  = {shift[6:0], sdaNow};
					next_bitCnt = bitCnt + 4'h1;
				end
				ISR_S_RDATA: begin
					next_bitCnt = bitCnt + 4'h1;
				end
				ISR_S_RACK: begin
					next_masterNack = sdaNow;
				end
				default: begin
				end
			endcase
		end else if (sclFall) begin
			case (state)
				ISR_S_ADDR: begin
					if (byteDone && addrHit) begin
						next_state  = ISR_S_ACKA;
						next_rnw    = shift[0];
						next_sdaLow = 1'b1;
					end else if (byteDone) begin
						next_state = ISR_S_IDLE;
					end
				end
				ISR_S_ACKA: begin
					next_bitCnt = 4'h0;
					if (rnw) begin
						next_state  = ISR_S_RDATA;
						next_shift  = txByte;
						next_sdaLow = !txByte[7];
					end else begin
						next_state  = ISR_S_PTR;
						next_sdaLow = 1'b0;
					end
				end
				ISR_S_PTR: begin
					if (byteDone) begin
						next_ptr    = shift[ISR_PTR_W-1:0];
						next_state  = ISR_S_ACKP;
						next_sdaLow = 1'b1;
					end
				end
				ISR_S_WDATA: begin
					if (byteDone) begin
						next_ptr    = ptr + 3'h1;
						next_state  = ISR_S_ACKW;
						next_sdaLow = 1'b1;
					end
				end
				ISR_S_ACKP, ISR_S_ACKW: begin
					next_state  = ISR_S_WDATA;
					next_bitCnt = 4'h0;
					next_sdaLow = 1'b0;
				end
				ISR_S_RDATA: begin
					if (byteDone) begin
						next_state  = ISR_S_RACK;
						next_ptr    = ptr + 3'h1;
						next_sdaLow = 1'b0;
					end else begin
						next_shift  = {shift[6:0], 1'b0};
						next_sdaLow = !shift[6];
					end
				end
				ISR_S_RACK: begin
					if (!masterNack) begin
						next_state  = ISR_S_RDATA;
						next_bitCnt = 4'h0;
						next_shift  = txByte;
						next_sdaLow = !txByte[7];
					end else begin
						next_state  = ISR_S_IDLE;
						next_sdaLow = 1'b0;
					end
				end
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge linkClk or negedge rst_b) begin
		if (!rst_b) begin
			state      <= ISR_S_IDLE;
			shift      <= 8'h00;
			bitCnt     <= 4'h0;
			ptr        <= 3'h0;
			rnw        <= 1'b0;
			masterNack <= 1'b1;
			sdaLow     <= 1'b0;
			sclPrev    <= 1'b1;
			sdaPrev    <= 1'b1;
			busActive  <= 1'b0;
		end else begin
			state      <= next_state;
			shift      <= next_shift;
			bitCnt     <= next_bitCnt;
			ptr        <= next_ptr;
			rnw        <= next_rnw;
			masterNack <= next_masterNack;
			sdaLow     <= next_sdaLow;
			sclPrev    <= sclNow;
			sdaPrev    <= sdaNow;
			busActive  <= next_state != ISR_S_IDLE;
		end
	end

	always_ff @(posedge linkClk or negedge rst_b) begin
		if (!rst_b) begin
			cfgOut <= ISR_REG_RESET;
		end else if (commitNow) begin
			cfgOut[{ptr, 3'h0} +: 8] <= shift;
		end
	end
endmodule

// ===== hdl/isr_master_end.sv
// Master end: drives SCL from its own clock and runs register write and read commands.
// Assumes a single master on the bus and no clock stretching by the slave.
module isr_master_end
	import isr_pkg::*;
#(
	parameter int QUARTER = ISR_SCL_QUARTER
) (
	input  wire logic        clock,
	input  wire logic        rst_b,
	isr_if.host              bus,
	input  wire logic        req,
	input  wire logic        rnw,
	input  wire logic [2:0]  regAddr,
	input  wire logic [3:0]  len,
	input  wire logic [63:0] wrData,
	input  wire logic        devSel,
	output logic             busy,
	output logic             done,
	output logic             nack,
	output logic      [63:0] rdData
);
	isr_host_state_t       state;
	isr_byte_kind_t        kind;
	logic           [15:0] div;
	logic            [1:0] q;
	logic            [3:0] bitN;
	logic            [7:0] shift;
	logic            [3:0] remain;
	logic            [2:0] idx;
	logic                  isRead;
	logic                  ackBit;
	logic                  sclLow;
	logic                  sdaLow;
	logic            [2:0] ptrReq;
	logic           [63:0] wrBuf;
	logic                  sdaIn;

	wire       tick     = div == 16'h0000;
	wire       lastBit  = bitN == ISR_BITS_PER_BYTE;
	wire       sending  = kind != ISR_K_RD;
	wire [6:0] devAddr  = {ISR_ADDR_HI, devSel, ISR_ADDR_LO};
	wire [7:0] nextWr   = wrBuf[{idx + 3'h1, 3'h0} +: 8];

	if (QUARTER < 1 || QUARTER > 65535) begin : g_chk
		$error("isr_master_end QUARTER out of range");
	end

	isr_sync3 #(
		.W    (1),
		.INIT (1'b1)
	) u_sync (
		.clock (clock),
		.rst_b (rst_b),
		.din   (bus.sda),
		.dout  (sdaIn)
	);

	assign bus.sclHostOut = 1'b0;
	assign bus.sclHostOe  = sclLow;
	assign bus.sdaHostOut = 1'b0;
	assign bus.sdaHostOe  = sdaLow;

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			state  <= ISR_H_IDLE;
			kind   <= ISR_K_ADDRW;
			div    <= 16'h0000;
			q      <= 2'h0;
			bitN   <= 4'h0;
			shift  <= 8'h00;
			remain <= 4'h0;
			idx    <= 3'h0;
			isRead <= 1'b0;
			ackBit <= 1'b1;
			sclLow <= 1'b0;
			sdaLow <= 1'b0;
			ptrReq <= 3'h0;
			wrBuf  <= 64'h0000_0000_0000_0000;
			busy   <= 1'b0;
			done   <= 1'b0;
			nack   <= 1'b0;
			rdData <= 64'h0000_0000_0000_0000;
		end else begin
			done <= 1'b0;
			div  <= tick ? 16'(QUARTER - 1) : div - 16'h0001;
			if (state == ISR_H_IDLE) begin
				q   <= 2'h0;
				div <= 16'(QUARTER - 1);
				if (req && sdaIn) begin
					state  <= ISR_H_START;
					busy   <= 1'b1;
					nack   <= 1'b0;
					isRead <= rnw;
					ptrReq <= regAddr;
					wrBuf  <= wrData;
					remain <= (len == 4'h0) ? 4'h1 : len;
					idx    <= 3'h0;
				end
			end else if (tick) begin
				q <= q + 2'h1;
				case (state)
					ISR_H_START, ISR_H_RSTART: begin
						if (q == 2'h0) begin
							sdaLow <= 1'b0;
						end else if (q == 2'h1) begin
							sclLow <= 1'b0;
						end else if (q == 2'h2) begin
							sdaLow <= 1'b1;
						end else begin
							sclLow <= 1'b1;
							state  <= ISR_H_XFER;
							bitN   <= 4'h0;
							kind   <= (state == ISR_H_START) ? ISR_K_ADDRW : ISR_K_ADDRR;
							shift  <= {devAddr, state == ISR_H_RSTART};
						end
					end
					ISR_H_XFER: begin
						if (q == 2'h0) begin
							if (sending) begin
								sdaLow <= lastBit ? 1'b0 : !shift[7];
							end else begin
								sdaLow <= lastBit && remain != 4'h1;
							end
						end else if (q == 2'h1) begin
							sclLow <= 1'b0;
						end else if (q == 2'h2) begin
							if (lastBit) begin
								ackBit <= sdaIn;
							end else begin
								shift <= {shift[6:0], sdaIn};
							end
						end else begin
							sclLow <= 1'b1;
							if (!lastBit) begin
								bitN <= bitN + 4'h1;
							end else begin
								bitN <= 4'h0;
								if (sending && ackBit) begin
									nack  <= 1'b1;
									state <= ISR_H_STOP;
								end else begin
									case (kind)
										ISR_K_ADDRW: begin
											kind  <= ISR_K_PTR;
											shift <= {5'h00, ptrReq};
										end
										ISR_K_PTR: begin
											if (isRead) begin
												state <= ISR_H_RSTART;
											end else begin
												kind  <= ISR_K_DATA;
												shift <= wrBuf[7:0];
											end
										end
										ISR_K_DATA: begin
											remain <= remain - 4'h1;
											idx    <= idx + 3'h1;
											shift  <= nextWr;
											if (remain == 4'h1) begin
												state <= ISR_H_STOP;
											end
										end
										ISR_K_ADDRR: begin
											kind <= ISR_K_RD;
										end
										default: begin
											rdData[{idx, 3'h0} +: 8] <= shift;
											remain <= remain - 4'h1;
											idx    <= idx + 3'h1;
											if (remain == 4'h1) begin
												state <= ISR_H_STOP;
											end
										end
									endcase
								end
							end
						end
					end
					ISR_H_STOP: begin
						if (q == 2'h0) begin
							sdaLow <= 1'b1;
						end else if (q == 2'h1) begin
							sclLow <= 1'b0;
						end else if (q == 2'h2) begin
							sdaLow <= 1'b0;
						end else begin
							state <= ISR_H_IDLE;
							busy  <= 1'b0;
							done  <= 1'b1;
						end
					end
					default: begin
						state <= ISR_H_IDLE;
					end
				endcase
			end
		end
	end
endmodule

// ===== dv/isr_link_asserts.sv
// Assertions on the two-wire link between the master end and the slave end.
// Assumes SCL phases far longer than linkClk; sees the wired lines and the slave SDA enable.
module isr_link_asserts (
	input wire logic linkClk,
	input wire logic rst_b,
	input wire logic addrSel,
	input wire logic sdaDevOe,
	input wire logic scl,
	input wire logic sda
);
	logic       sclQ;
	logic       sdaQ;
	logic       inFrame;
	logic       addrOk;
	logic       rdMode;
	logic       nackRel;
	logic [3:0] bitCnt;
	logic [2:0] byteCnt;
	logic [7:0] shiftReg;
	wire        sclRise   = scl && !sclQ;
	wire        sclFall   = !scl && sclQ;
	wire        startSeen = scl && sclQ && sdaQ && !sda;
	wire        stopSeen  = scl && sclQ && !sdaQ && sda;
	wire        match     = shiftReg[7:1] == {4'hB, addrSel, 2'h0};
	wire        ackPoint  = sclFall && bitCnt == 4'h8 && byteCnt == 3'h0;

	always_ff @(posedge linkClk or negedge rst_b) begin
		if (!rst_b) begin
			sclQ    <= 1'b1;
			sdaQ    <= 1'b1;
			inFrame <= 1'b0;
		end else begin
			sclQ    <= scl;
			sdaQ    <= sda;
			inFrame <= startSeen || (inFrame && !stopSeen);
		end
	end

	// Bit cells numbered 1 to 9 by SCL rises, bytes counted since START
	always_ff @(posedge linkClk or negedge rst_b) begin
		if (!rst_b) begin
			bitCnt   <= 4'h0;
			byteCnt  <= 3'h0;
			shiftReg <= 8'h00;
		end else if (startSeen) begin
			bitCnt  <= 4'h0;
			byteCnt <= 3'h0;
		end else begin
			if (sclRise)
				bitCnt <= (bitCnt == 4'h9) ? 4'h1 : bitCnt + 4'h1;
			if (sclRise && bitCnt != 4'h8)
				shiftReg <= {shiftReg[6:0], sda};
			if (sclFall && bitCnt == 4'h9 && byteCnt != 3'h7)
				byteCnt <= byteCnt + 3'h1;
		end
	end

	always_ff @(posedge linkClk or negedge rst_b) begin
		if (!rst_b) begin
			addrOk  <= 1'b0;
			rdMode  <= 1'b0;
			nackRel <= 1'b0;
		end else if (startSeen || stopSeen) begin
			addrOk  <= 1'b0;
			nackRel <= 1'b0;
		end else begin
			if (ackPoint) begin
				addrOk <= match;
				rdMode <= shiftReg[0];
			end
			if (sclRise && bitCnt == 4'h8 && addrOk && rdMode && byteCnt != 3'h0 && sda)
				nackRel <= 1'b1;
		end
	end

	default clocking cb @(posedge linkClk); endclocking
	default disable iff (!rst_b);

	a_addr_ack_match: assert property (ackPoint && match |-> ##[1:12] sdaDevOe)
		else $error("own address not acknowledged");
	a_other_no_ack: assert property (ackPoint && !match |-> !sdaDevOe [*8])
		else $error("foreign address acknowledged");
	a_idle_no_drive: assert property (!inFrame |-> !sdaDevOe)
		else $error("slave drives outside a frame");
	a_nack_release: assert property (nackRel |-> !sdaDevOe)
		else $error("slave drives after master nack");
	a_data_stable: assert property ($rose(scl) |=> $stable(sda) [*8])
		else $error("data moved while clock high");
	a_dev_low_phase: assert property ($changed(sdaDevOe) |-> !scl)
		else $error("slave changed data while clock high");
	a_start_idle: assert property (startSeen && !inFrame |-> $past(sda, 8) && $past(scl, 8))
		else $error("start without idle bus");
	a_write_ack_low: assert property (addrOk && !rdMode && bitCnt == 4'h9 && scl && sclQ |-> !sda)
		else $error("write byte not acknowledged");

	c_addr_ack: cover property (ackPoint && match);
	c_addr_miss: cover property (ackPoint && !match);
	c_read_nack: cover property (nackRel);
endmodule

// ===== dv/testbench.sv
// Testbench: master and slave ends on one link, and a bit-driven second slave.
// Assumes a shortened SCL quarter of Q clock cycles.
module testbench;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int Q = 10;
	logic        clock = 1'b0;
	logic        linkClk = 1'b0;
	logic        rst_b = 1'b0;
	logic        req = 1'b0;
	logic        rnw = 1'b0;
	logic [2:0]  regAddr = 3'h0;
	logic [3:0]  len = 4'h0;
	logic [63:0] wrData = 64'h0;
	logic        devSel = 1'b0;
	logic        addrSel = 1'b0;
	logic        lockStatus = 1'b0;
	logic        busy, done, nack, busActive;
	logic [63:0] rdData, cfgOut, cfgOut2;
	logic [63:0] model = 64'h0;
	int          error_cnt = 0;
	int          samples_checked = 0;
	int          cycles = 0;

	isr_if isr_if_inst ();
	isr_if isr_if_inst2 ();
	isr_master_end #(.QUARTER(Q)) isr_master_end_inst (.clock(clock), .rst_b(rst_b), .bus(isr_if_inst),
		.req(req), .rnw(rnw), .regAddr(regAddr), .len(len), .wrData(wrData), .devSel(devSel),
		.busy(busy), .done(done), .nack(nack), .rdData(rdData));
	isr_slave_end isr_slave_end_inst (.linkClk(linkClk), .rst_b(rst_b), .bus(isr_if_inst),
		.addrSel(addrSel), .lockStatus(lockStatus), .cfgOut(cfgOut), .busActive(busActive));
	isr_slave_end isr_slave_end_inst2 (.linkClk(linkClk), .rst_b(rst_b), .bus(isr_if_inst2),
		.addrSel(1'b1), .lockStatus(1'b0), .cfgOut(cfgOut2), .busActive());
	isr_link_asserts isr_link_asserts_inst (.linkClk(linkClk), .rst_b(rst_b), .addrSel(addrSel),
		.sdaDevOe(isr_if_inst.sdaDevOe), .scl(isr_if_inst.scl), .sda(isr_if_inst.sda));
	assign isr_if_inst2.sclHostOut = 1'b0;
	assign isr_if_inst2.sdaHostOut = 1'b0;

	always #5 clock = ~clock;
	initial begin
		#1.7;
		forever #3 linkClk = ~linkClk;
	end

	always @(posedge clock) begin
		cycles++;
		if (cycles == 90000) begin
			error_cnt++;
			stop_test();
		end
	end

	task automatic stop_test();
		if (error_cnt == 0 && samples_checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			error_cnt++;
			$display("unexpected %s expected %h seen %h", name, exp, seen);
		end
	endtask

	function automatic logic [63:0] wrExp(input logic [63:0] m, input logic [63:0] w,
		input logic [2:0] r, input logic [3:0] n);
		for (int i = 0; i < ((n == 4'h0) ? 1 : int'(n)); i++)
			m[8*((r+i)%8)+:8] = w[8*(i%8)+:8];
		return m;
	endfunction

	// Read bytes come from the pointer onward; the top bit of register 7 is live
	function automatic logic [63:0] rdExp(input logic [63:0] m, input logic [2:0] r,
		input logic [3:0] n, input logic lk, output logic [63:0] mask);
		m[63] = lk;
		mask = 64'h0;
		rdExp = 64'h0;
		for (int i = 0; i < ((n == 4'h0) ? 1 : int'(n)); i++) begin
			rdExp[8*i+:8] = m[8*((r+i)%8)+:8];
			mask[8*i+:8] = 8'hFF;
		end
	endfunction

	task automatic doCmd(input logic rd, input logic [2:0] r, input logic [3:0] n,
		input logic [63:0] w, input logic ds);
		logic [63:0] e;
		logic [63:0] mask;
		@(posedge clock);
		req     <= 1'b1;
		rnw     <= rd;
		regAddr <= r;
		len     <= n;
		wrData  <= w;
		devSel  <= ds;
		@(posedge clock);
		req <= 1'b0;
		#1;
		for (int k = 0; k < 9000 && done !== 1'b1; k++) begin
			@(posedge clock);
			#1;
		end
		check("done", 64'(done), 64'h1);
		check("busy", 64'(busy), 64'h0);
		e = rdExp(model, r, n, lockStatus, mask);
		if (ds === addrSel && rd)
			check("rdData", rdData & mask, e);
		if (ds === addrSel && !rd)
			model = wrExp(model, w, r, n);
		check("cfgOut", cfgOut, model);
		check("nack", 64'(nack), 64'(ds !== addrSel));
		check("busActive", 64'(busActive), 64'h0);
	endtask

	// Bit-level driver for the second link; each phase lasts one quarter
	task automatic ph(input logic sclLow, input logic sdaLow);
		isr_if_inst2.sclHostOe <= sclLow;
		isr_if_inst2.sdaHostOe <= sdaLow;
		repeat (Q) @(posedge clock);
	endtask

	task automatic bitx(input logic b, output logic s);
		ph(1'b1, !b);
		ph(1'b0, !b);
		s = isr_if_inst2.sda;
		ph(1'b0, !b);
		ph(1'b1, !b);
	endtask

	task automatic sendBits(input logic [7:0] v, input int nb, output logic acked);
		logic s;
		for (int i = 7; i > 7 - nb; i--)
			bitx(v[i], s);
		if (nb == 8)
			bitx(1'b1, s);
		acked = (nb == 8) && !s;
	endtask

	task automatic startC();
		ph(1'b1, 1'b0);
		ph(1'b0, 1'b0);
		ph(1'b0, 1'b1);
		ph(1'b1, 1'b1);
	endtask

	task automatic stopC();
		ph(1'b1, 1'b1);
		ph(1'b0, 1'b1);
		ph(1'b0, 1'b0);
	endtask

	initial begin
		logic ack;
		logic rd;
		isr_if_inst2.sclHostOe = 1'b0;
		isr_if_inst2.sdaHostOe = 1'b0;
		void'($urandom(32'h0000_7A88));
		repeat (10) @(posedge clock);
		rst_b <= 1'b1;
		repeat (4) @(posedge clock);
		check("cfgOut", cfgOut, 64'h0);
		startC();
		sendBits(8'h00, 8, ack);
		check("generalCallAck", 64'(ack), 64'h0);
		stopC();
		startC();
		sendBits(8'hB0, 8, ack);
		check("otherAddrAck", 64'(ack), 64'h0);
		stopC();
		startC();
		sendBits(8'hB8, 8, ack);
		check("addrAck", 64'(ack), 64'h1);
		sendBits(8'h03, 8, ack);
		sendBits(8'h3C, 8, ack);
		check("dataAck", 64'(ack), 64'h1);
		check("cfgOut2", cfgOut2, 64'h0000_0000_3C00_0000);
		sendBits(8'hFF, 5, ack);
		stopC();
		startC();
		sendBits(8'hB8, 8, ack);
		sendBits(8'h05, 8, ack);
		sendBits(8'hAA, 3, ack);
		startC();
		stopC();
		check("cfgOut2", cfgOut2, 64'h0000_0000_3C00_0000);
		doCmd(1'b0, 3'h5, 4'hC, 64'h0123_4567_89AB_CDEF, 1'b0);
		lockStatus <= 1'b1;
		doCmd(1'b1, 3'h3, 4'h8, 64'h0, 1'b0);
		doCmd(1'b0, 3'h1, 4'h1, 64'hFF, 1'b1);
		addrSel <= 1'b1;
		lockStatus <= 1'b0;
		doCmd(1'b0, 3'h7, 4'h1, 64'h80, 1'b1);
		doCmd(1'b1, 3'h7, 4'h1, 64'h0, 1'b1);
		for (int t = 0; t < 7; t++) begin
			rd = 1'($urandom_range(1));
			lockStatus <= 1'($urandom_range(1));
			doCmd(rd, 3'($urandom_range(7)), 4'($urandom_range(rd ? 8 : 12, 1)), {$urandom, $urandom}, addrSel);
		end
		stop_test();
	end
endmodule
